// ===== design/mic_interrupt_controller.sv
// Functional notes
// - Only strictly higher level pre-empts a service
// - Return ends service, restores previous level
// - Flags set whether enabled or not
// - Sample each machine cycle, call next cycle
// - Equal or higher service blocks new request
// - Detect one cycle, core spends six calling
// - Global enable low blocks every interrupt
// - Enable bits 4..0 gate five core sources
// - Request register holds flags 6..2 in bits 5..1
// - Group sources masked, ORed, flagged separately
// - User port drives high and low paths
// - Two pins with selectable edge polarity
// - Groups: card, usb/clock/keypad, i2c/fault/compare
// - Group outputs converted to rising edges
// - Core flag cleared when core takes vector
// - Reading a group register clears its flags
// - Vectors from 0x0003, eight bytes apart
`timescale 1ns/1ps
`default_nettype none
module mic_interrupt_controller (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic machine_cycle,
    input wire logic call_ack,
    input wire logic return_from_interrupt,
    output logic irq_call,
    output logic [15:0] irq_vector,
    output logic servicing,
    input wire logic [7:0] user_port_pins,
    input wire logic [7:0] user_port_irq_hi_select,
    input wire logic [7:0] user_port_irq_lo_select,
    input wire logic [7:0] user_port_irq_invert,
    input wire logic irq_pin_a,
    input wire logic irq_pin_b,
    input wire logic irq_pin_a_rising,
    input wire logic irq_pin_b_rising,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic serial0_request,
    input wire logic [mic_pkg::GRP_SRC-1:0] smart_card_events,
    input wire logic [mic_pkg::GRP_SRC-1:0] usb_rtc_keypad_events,
    input wire logic [mic_pkg::GRP_SRC-1:0] i2c_fault_compare_events
);
    import mic_pkg::*;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_s3;
    logic [NPIN-1:0] pin_level;
    logic [7:0] interrupt_enable_0;
    logic [7:0] ien1;
    logic [7:0] interrupt_request_flags;
    logic [7:0] prio;
    logic ext0_flag;
    logic ext1_flag;
    logic t0_flag;
    logic t1_flag;
    logic [3:0] edge_now;
    logic [3:0] edge_prev;
    logic [3:0] edge_rise;
    logic [GRP_SRC-1:0] grp_ev [NGRP];
    logic [GRP_SRC-1:0] grp_en [NGRP];
    logic [GRP_SRC-1:0] grp_fl [NGRP];
    logic [7:0] grp_rd_val [NGRP];
    logic [NGRP-1:0] grp_hit;
    logic [NGRP-1:0] grp_any;
    logic [NGRP-1:0] grp_prev;
    logic [NGRP-1:0] grp_rise;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] en_vec;
    logic [NSRC-1:0] lvl_hi;
    logic [NSRC-1:0] elig;
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] req_hi;
    logic [NSRC-1:0] pick;
    logic [NSRC-1:0] clr_src;
    logic [3:0] win;
    logic [3:0] sel_src;
    logic [3:0] sel_slot;
    logic sel_hi;
    logic in_hi;
    logic in_lo;
    logic next_in_hi;
    logic next_in_lo;
    mic_state_t st;
    wire ack_take;
    wire any_req;
    wire interrupt_enable_0_wr;
    wire ien1_wr;
    wire interrupt_request_flags_wr;
    wire prio_wr;
    wire [7:0] interrupt_request_flags_set;
    wire [7:0] interrupt_request_flags_clr;
    wire [7:0] next_interrupt_request_flags;
    wire [7:0] grp_mux;
    wire [7:0] rd_mux;
    wire [15:0] next_vector;

    // Three stages; a level only counts once stages two and three agree
    assign pin_raw = {irq_pin_b, irq_pin_a, user_port_pins};
    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_sync
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    pin_s1[i] <= 1'b0;
                    pin_s2[i] <= 1'b0;
                    pin_s3[i] <= 1'b0;
                    pin_level[i] <= 1'b0;
                end else begin
                    pin_s1[i] <= pin_raw[i];
                    pin_s2[i] <= pin_s1[i];
                    pin_s3[i] <= pin_s2[i];
                    if (pin_s2[i] == pin_s3[i]) begin
                        pin_level[i] <= pin_s3[i];
                    end
                end
            end
        end
    endgenerate

    // Changing a polarity select while a pin sits active can fake one edge
    assign edge_now[0] = |((pin_level[7:0] ^ user_port_irq_invert)
                           & user_port_irq_hi_select);
    assign edge_now[1] = |((pin_level[7:0] ^ user_port_irq_invert)
                           & user_port_irq_lo_select);
    assign edge_now[2] = pin_level[PIN_A] ~^ irq_pin_a_rising;
    assign edge_now[3] = pin_level[PIN_B] ~^ irq_pin_b_rising;
    assign edge_rise = edge_now & ~edge_prev;
    assign grp_ev[0] = smart_card_events;
    assign grp_ev[1] = usb_rtc_keypad_events;
    assign grp_ev[2] = i2c_fault_compare_events;
    generate
        for (genvar k = 0; k < NGRP; k++) begin : g_grp
            assign grp_hit[k] = sfr_addr == GRP_ADDR[k*8 +: 8];
            assign grp_any[k] = |(grp_fl[k] & grp_en[k]);
            assign grp_rise[k] = grp_any[k] & ~grp_prev[k];
            assign grp_rd_val[k][7:2*GRP_SRC] = '0;
            for (genvar j = 0; j < GRP_SRC; j++) begin : g_bit
                assign grp_rd_val[k][2*j] = grp_fl[k][j];
                assign grp_rd_val[k][2*j+1] = grp_en[k][j];
            end
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    grp_en[k] <= '0;
                    grp_fl[k] <= '0;
                    grp_prev[k] <= 1'b0;
                end else begin
                    if (sfr_wr && grp_hit[k]) begin
                        for (int j = 0; j < GRP_SRC; j++) begin
                            grp_en[k][j] <= sfr_wdata[2*j+1];
                        end
                    end
                    // New events win over the clear caused by a read
                    grp_fl[k] <= grp_ev[k]
                                 | ((sfr_rd && grp_hit[k]) ? '0 : grp_fl[k]);
                    grp_prev[k] <= grp_any[k];
                end
            end
        end
    endgenerate

    assign interrupt_enable_0_wr = sfr_wr && sfr_addr == ADDR_INTERRUPT_ENABLE_0;
    assign ien1_wr = sfr_wr && sfr_addr == ADDR_IEN1;
    assign interrupt_request_flags_wr = sfr_wr && sfr_addr == ADDR_INTERRUPT_REQUEST_FLAGS;
    assign prio_wr = sfr_wr && sfr_addr == ADDR_PRIO;
    assign ack_take = st == ST_CALL && call_ack;
    assign interrupt_request_flags_set = {2'b00, grp_rise, edge_rise[3:2], 1'b0};
    assign interrupt_request_flags_clr = {2'b00, clr_src[9], clr_src[8], clr_src[6],
                        clr_src[4], clr_src[2], 1'b0};
    assign next_interrupt_request_flags = (((interrupt_request_flags_wr ? sfr_wdata : interrupt_request_flags) & ~interrupt_request_flags_clr)
                         | interrupt_request_flags_set) & INTERRUPT_REQUEST_FLAGS_MASK;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            interrupt_enable_0 <= RESET_VAL;
            ien1 <= RESET_VAL;
            interrupt_request_flags <= RESET_VAL;
            prio <= RESET_VAL;
            edge_prev <= '1; // No false edge from a pin resting active low at reset
        end else begin
            if (interrupt_enable_0_wr) begin
                interrupt_enable_0 <= sfr_wdata & INTERRUPT_ENABLE_0_MASK;
            end
            if (ien1_wr) begin
                ien1 <= sfr_wdata & IEN1_MASK;
            end
            if (prio_wr) begin
                prio <= sfr_wdata & PRIO_MASK;
            end
            interrupt_request_flags <= next_interrupt_request_flags;
            edge_prev <= edge_now;
        end
    end

    // Core-level flags: set by hardware, cleared when the vector is taken
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ext0_flag <= 1'b0;
            ext1_flag <= 1'b0;
            t0_flag <= 1'b0;
            t1_flag <= 1'b0;
        end else begin
            ext0_flag <= edge_rise[0] | (ext0_flag & ~clr_src[SRC_EXT0]);
            ext1_flag <= edge_rise[1] | (ext1_flag & ~clr_src[SRC_EXT1]);
            t0_flag <= timer0_overflow | (t0_flag & ~clr_src[1]);
            t1_flag <= timer1_overflow | (t1_flag & ~clr_src[5]);
        end
    end

    // Serial request is a level owned by the channel and is not cleared here
    assign pend = {interrupt_request_flags[BIT_X6], interrupt_request_flags[BIT_X5], serial0_request, interrupt_request_flags[BIT_X4],
                   t1_flag, interrupt_request_flags[BIT_X3], ext1_flag, interrupt_request_flags[BIT_X2], t0_flag,
                   ext0_flag};
    assign en_vec = {ien1[BIT_X6], ien1[BIT_X5], interrupt_enable_0[BIT_SER], ien1[BIT_X4],
                     interrupt_enable_0[BIT_T1], ien1[BIT_X3], interrupt_enable_0[BIT_EXT1], ien1[BIT_X2],
                     interrupt_enable_0[BIT_T0], interrupt_enable_0[BIT_EXT0]};

    generate
        for (genvar i = 0; i < NSRC; i++) begin : g_src
            assign lvl_hi[i] = prio[SRC_GROUP[i*3 +: 3]];
            assign elig[i] = lvl_hi[i] ? !in_hi : !(in_hi || in_lo);
            assign clr_src[i] = ack_take && sel_src == 4'(i);
        end
    endgenerate

    assign req = pend & en_vec & elig & {NSRC{interrupt_enable_0[BIT_GIE]}};
    assign req_hi = req & lvl_hi;
    assign pick = (|req_hi) ? req_hi : req;
    assign any_req = |req;
    // Fixed polling order: the lowest index among the chosen level wins
    always_comb begin
        win = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pick[i]) begin
                win = 4'(i);
            end
        end
    end

    assign sel_slot = SRC_SLOT[sel_src*4 +: 4];
    assign next_vector = VEC_BASE + 16'(sel_slot) * VEC_STEP;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st <= ST_IDLE;
            sel_src <= 4'h0;
            sel_hi <= 1'b0;
            irq_call <= 1'b0;
            irq_vector <= 16'h0000;
        end else begin
            unique case (st)
                ST_IDLE: begin
                    if (machine_cycle && any_req) begin
                        sel_src <= win;
                        sel_hi <= lvl_hi[win];
                        st <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (machine_cycle) begin
                        irq_call <= 1'b1;
                        irq_vector <= next_vector;
                        st <= ST_CALL;
                    end
                end
                ST_CALL: begin
                    if (call_ack) begin
                        irq_call <= 1'b0;
                        st <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Two service levels; a return leaves the higher one first
    always_comb begin
        next_in_hi = in_hi;
        next_in_lo = in_lo;
        if (ack_take) begin
            next_in_hi = in_hi | sel_hi;
            next_in_lo = in_lo | ~sel_hi;
        end else if (return_from_interrupt) begin
            if (in_hi) begin
                next_in_hi = 1'b0;
            end else begin
                next_in_lo = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            in_hi <= 1'b0;
            in_lo <= 1'b0;
            servicing <= 1'b0;
        end else begin
            in_hi <= next_in_hi;
            in_lo <= next_in_lo;
            servicing <= next_in_hi | next_in_lo;
        end
    end

    assign grp_mux = grp_hit[0] ? grp_rd_val[0] :
                     grp_hit[1] ? grp_rd_val[1] :
                     grp_hit[2] ? grp_rd_val[2] : 8'h00;
    assign rd_mux = (sfr_addr == ADDR_INTERRUPT_ENABLE_0) ? interrupt_enable_0 :
                    (sfr_addr == ADDR_INTERRUPT_REQUEST_FLAGS) ? interrupt_request_flags :
                    (sfr_addr == ADDR_IEN1) ? ien1 :
                    (sfr_addr == ADDR_PRIO) ? prio : grp_mux;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= rd_mux;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence detect_s;
        st == ST_IDLE && machine_cycle && any_req;
    endsequence
    sequence armed_s;
        st == ST_ARMED && machine_cycle;
    endsequence

    global_block_a: assert property (
        (st == ST_IDLE && !interrupt_enable_0[BIT_GIE]) |=> st == ST_IDLE)
        else $error("request taken with global enable low");
    source_mask_a: assert property (
        (st == ST_IDLE && machine_cycle && (pend & en_vec) == '0) |=> st == ST_IDLE)
        else $error("disabled source was taken");
    flag_set_a: assert property (
        (grp_rise[0] && !interrupt_request_flags_wr) |=> interrupt_request_flags[BIT_X4])
        else $error("group edge did not set its flag");
    call_timing_a: assert property (
        detect_s ##1 armed_s |=> irq_call && st == ST_CALL)
        else $error("long call not forced after detection");
    vector_form_a: assert property (
        $rose(irq_call) |-> irq_vector[2:0] == VEC_BASE[2:0] && irq_vector < 16'h0070)
        else $error("vector off the eight byte grid");
    equal_block_a: assert property (
        (st == ST_IDLE && in_hi && !return_from_interrupt) |=> st == ST_IDLE)
        else $error("new request during high level service");
    return_pop_a: assert property (
        (return_from_interrupt && !ack_take && in_hi) |=> !in_hi && in_lo == $past(in_lo))
        else $error("return did not end the higher service");
    auto_clear_a: assert property (
        (ack_take && sel_src == 4'(SRC_EXT0) && !edge_rise[0]) |=> !ext0_flag)
        else $error("core flag not cleared on vector");
    read_clear_a: assert property (
        (sfr_rd && grp_hit[2] && i2c_fault_compare_events == '0) |=> grp_fl[2] == '0)
        else $error("group flags survived a read");
    detect_one_a: assert property (
        detect_s |=> st == ST_ARMED && !irq_call)
        else $error("detection did not take one machine cycle");
endmodule // mic_interrupt_controller
`default_nettype wire

// ===== shared/mic_pkg.sv
`default_nettype none
package mic_pkg;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE_0 = 8'ha8;
    localparam logic [7:0] ADDR_INTERRUPT_REQUEST_FLAGS = 8'hc0;
    localparam logic [7:0] ADDR_IEN1 = 8'he4;
    localparam logic [7:0] ADDR_PRIO = 8'he5;
    // Group registers for external interrupts 4, 5 and 6, low byte first
    localparam logic [23:0] GRP_ADDR = 24'he3e2e1;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] INTERRUPT_ENABLE_0_MASK = 8'hdf;
    localparam logic [7:0] INTERRUPT_REQUEST_FLAGS_MASK = 8'h3e;
    localparam logic [7:0] IEN1_MASK = 8'h3e;
    localparam logic [7:0] PRIO_MASK = 8'h3f;
    // Enable register 0 fields
    localparam int BIT_EXT0 = 0;
    localparam int BIT_T0 = 1;
    localparam int BIT_EXT1 = 2;
    localparam int BIT_T1 = 3;
    localparam int BIT_SER = 4;
    localparam int BIT_GIE = 7;
    // Request flag and enable register 1 fields
    localparam int BIT_X2 = 1;
    localparam int BIT_X3 = 2;
    localparam int BIT_X4 = 3;
    localparam int BIT_X5 = 4;
    localparam int BIT_X6 = 5;
    // Pins: user port 7..0, then the two dedicated pins
    localparam int NPIN = 10;
    localparam int PIN_A = 8;
    localparam int PIN_B = 9;
    localparam int NGRP = 3;
    localparam int GRP_SRC = 3;
    // Sources in polling order, lowest index wins within a level
    localparam int NSRC = 10;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 3;
    // Vector slot of each source, 4 bits per source
    localparam logic [39:0] SRC_SLOT = 40'hdc4b3a2910;
    // Priority group of each source, 3 bits per source
    localparam logic [29:0] SRC_GROUP = {3'h5, 3'h4, 3'h4, 3'h3, 3'h3,
                                         3'h2, 3'h2, 3'h1, 3'h1, 3'h0};
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_CALL = 3'b100
    } mic_state_t;
endpackage
`default_nettype wire

// ===== sim/mic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic slow,
    input wire logic ret_req,
    input wire logic irq_call,
    output logic machine_cycle,
    output logic call_ack,
    output logic return_from_interrupt
);
    logic phase;
    logic ret_d;
    logic [2:0] cnt;
    // Drives on the falling edge so the controller sees settled inputs
    always @(negedge clock or posedge reset) begin
        if (reset) begin
            phase <= 1'b0;
            machine_cycle <= 1'b0;
            call_ack <= 1'b0;
            cnt <= 3'h0;
            ret_d <= 1'b0;
            return_from_interrupt <= 1'b0;
        end else begin
            phase <= slow ? ~phase : 1'b1;
            machine_cycle <= slow ? phase : 1'b1;
            // Six machine cycles of forced call before the core takes it
            if (!irq_call || call_ack) begin
                cnt <= 3'h0;
                call_ack <= 1'b0;
            end else if (machine_cycle) begin
                if (cnt == 3'h5) begin
                    call_ack <= 1'b1;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end
            ret_d <= ret_req;
            return_from_interrupt <= ret_req && !ret_d;
        end
    end
endmodule // mic_core_model
`default_nettype wire

// ===== sim/mic_interrupt_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mic_interrupt_controller_bench;
    import mic_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, slow = 1'b0, ret_req = 1'b0;
    logic machine_cycle, call_ack, return_from_interrupt, irq_call, servicing;
    logic [15:0] irq_vector;
    logic [7:0] user_port_pins = 8'h01, user_port_irq_invert = 8'h01;
    logic [7:0] user_port_irq_hi_select = 8'h01, user_port_irq_lo_select = 8'h02;
    logic irq_pin_a = 1'b0, irq_pin_b = 1'b0, irq_pin_a_rising = 1'b1, irq_pin_b_rising = 1'b0;
    logic timer0_overflow = 1'b0, timer1_overflow = 1'b0, serial0_request = 1'b0;
    logic [2:0] smart_card_events = 3'h0, usb_rtc_keypad_events = 3'h0;
    logic [2:0] i2c_fault_compare_events = 3'h0;
    logic rd_seen = 1'b0, call_q = 1'b0;
    logic [7:0] rq[$];
    logic [15:0] vq[$];
    logic [7:0] d;
    int n_fail = 0;
    int samples_checked = 0;
    int slot [10] = '{0, 1, 2, 3, 4, 9, 10, 11, 12, 13};

    always #2.5 clock = ~clock;

    mic_interrupt_controller uut (.clock(clock), .reset(reset), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .machine_cycle(machine_cycle), .call_ack(call_ack),
        .return_from_interrupt(return_from_interrupt), .irq_call(irq_call),
        .irq_vector(irq_vector), .servicing(servicing), .user_port_pins(user_port_pins),
        .user_port_irq_hi_select(user_port_irq_hi_select),
        .user_port_irq_lo_select(user_port_irq_lo_select),
        .user_port_irq_invert(user_port_irq_invert), .irq_pin_a(irq_pin_a),
        .irq_pin_b(irq_pin_b), .irq_pin_a_rising(irq_pin_a_rising),
        .irq_pin_b_rising(irq_pin_b_rising), .timer0_overflow(timer0_overflow),
        .timer1_overflow(timer1_overflow), .serial0_request(serial0_request),
        .smart_card_events(smart_card_events), .usb_rtc_keypad_events(usb_rtc_keypad_events),
        .i2c_fault_compare_events(i2c_fault_compare_events));

    mic_core_model core (.clock(clock), .reset(reset), .slow(slow), .ret_req(ret_req),
        .irq_call(irq_call), .machine_cycle(machine_cycle), .call_ack(call_ack),
        .return_from_interrupt(return_from_interrupt));

    task automatic stop_test();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] vec(input int s);
        return VEC_BASE + VEC_STEP * 16'(slot[s]);
    endfunction

    // Read data is registered, so it is judged one cycle after the strobe
    always @(posedge clock) rd_seen <= sfr_rd;
    always @(negedge clock) begin
        if (rd_seen) begin
            chk({8'h00, sfr_rdata}, {8'h00, rq.pop_front()});
        end
        // A call nobody expected meets an unknown and always mismatches
        if (irq_call === 1'b1 && call_q !== 1'b1) begin
            chk(irq_vector, vq.size() != 0 ? vq.pop_front() : 16'hxxxx);
        end
        call_q = irq_call;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        rq.push_back(e);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clock);
        sfr_rd = 1'b0;
    endtask

    // One bit per source in vector slot order; pins and the serial level stay up six cycles
    task automatic fire(input logic [9:0] m);
        @(negedge clock);
        user_port_pins = {6'h00, m[2], !m[0]};
        timer0_overflow = m[1];
        timer1_overflow = m[3];
        serial0_request = m[4];
        irq_pin_a = m[5];
        irq_pin_b = m[6];
        smart_card_events = {2'b00, m[7]};
        usb_rtc_keypad_events = {1'b0, m[8], 1'b0};
        i2c_fault_compare_events = {m[9], 2'b00};
        @(negedge clock);
        {timer0_overflow, timer1_overflow} = 2'b00;
        smart_card_events = 3'h0;
        usb_rtc_keypad_events = 3'h0;
        i2c_fault_compare_events = 3'h0;
        cyc(5);
        user_port_pins = 8'h01;
        {serial0_request, irq_pin_a, irq_pin_b} = 3'b000;
    endtask

    task automatic serve();
        int i;
        i = 0;
        while (call_ack !== 1'b1 && i < 300) begin
            @(posedge clock);
            i++;
        end
        if (i == 300) begin
            n_fail++;
            $display("[ERR] %0t call never taken", $time);
        end
        cyc(3);
        chk({15'h0000, servicing}, 16'h0001);
    endtask

    task automatic back();
        @(negedge clock);
        ret_req <= 1'b1;
        @(negedge clock);
        ret_req <= 1'b0;
        cyc(4);
    endtask

    initial begin
        #100000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        void'($urandom(32'h58941a6c));
        repeat (20) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        rd(ADDR_INTERRUPT_ENABLE_0, RESET_VAL);
        rd(ADDR_INTERRUPT_REQUEST_FLAGS, RESET_VAL);
        wr(ADDR_INTERRUPT_ENABLE_0, 8'hff);
        rd(ADDR_INTERRUPT_ENABLE_0, INTERRUPT_ENABLE_0_MASK);
        wr(ADDR_INTERRUPT_ENABLE_0, 8'h00);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        repeat (4) begin
            d = 8'($urandom);
            wr(ADDR_PRIO, d);
            rd(ADDR_PRIO, d & PRIO_MASK);
            wr(ADDR_IEN1, d);
            rd(ADDR_IEN1, d & IEN1_MASK);
        end
        wr(ADDR_INTERRUPT_REQUEST_FLAGS, 8'hff);
        rd(ADDR_INTERRUPT_REQUEST_FLAGS, INTERRUPT_REQUEST_FLAGS_MASK);
        wr(ADDR_INTERRUPT_REQUEST_FLAGS, 8'h00);
        wr(ADDR_IEN1, 8'h00);
        wr(ADDR_PRIO, 8'h00);
        wr(GRP_ADDR[7:0], 8'h2a);
        fire(10'h080);
        rd(GRP_ADDR[7:0], 8'h2b);
        rd(GRP_ADDR[7:0], 8'h2a);
        rd(ADDR_INTERRUPT_REQUEST_FLAGS, 8'h08);
        wr(ADDR_INTERRUPT_REQUEST_FLAGS, 8'h00);
        fire(10'h020);
        rd(ADDR_INTERRUPT_REQUEST_FLAGS, 8'h02);
        wr(ADDR_IEN1, 8'h02);
        cyc(20);
        vq.push_back(vec(5));
        wr(ADDR_INTERRUPT_ENABLE_0, 8'h80);
        serve();
        rd(ADDR_INTERRUPT_REQUEST_FLAGS, 8'h00);
        back();
        wr(ADDR_INTERRUPT_ENABLE_0, 8'h9f);
        wr(ADDR_IEN1, IEN1_MASK);
        wr(GRP_ADDR[15:8], 8'h2a);
        wr(GRP_ADDR[23:16], 8'h2a);
        for (int s = 0; s < 10; s++) begin
            vq.push_back(vec(s));
            fire(10'(1 << s));
            serve();
            back();
        end
        rd(GRP_ADDR[7:0], 8'h2b);
        rd(GRP_ADDR[15:8], 8'h2e);
        rd(GRP_ADDR[23:16], 8'h3a);
        slow <= 1'b1;
        vq.push_back(vec(7));
        vq.push_back(vec(8));
        fire(10'h180);
        serve();
        cyc(20);
        chk({15'h0000, irq_call}, 16'h0000);
        back();
        serve();
        back();
        wr(ADDR_PRIO, 8'h04);
        vq.push_back(vec(5));
        fire(10'h020);
        serve();
        vq.push_back(vec(6));
        fire(10'h040);
        serve();
        back();
        back();
        wr(ADDR_INTERRUPT_ENABLE_0, 8'h80);
        fire(10'h002);
        cyc(20);
        chk({15'h0000, servicing}, 16'h0000);
        chk(16'(vq.size()), 16'h0000);
        stop_test();
    end
endmodule // mic_interrupt_controller_bench
`default_nettype wire
